// [logic/slc_consts.svh]
`ifndef SLC_CONSTS_SVH
`define SLC_CONSTS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SLC_ADDR_SYNC     12'h203
`define SLC_ADDR_CTRL     12'h204
`define SLC_ADDR_TEST     12'h205
`define SLC_ADDR_PINS     12'h210
`define SLC_ADDR_STATUS   12'h211
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SLC_RST_SYNC      8'h01
`define SLC_RST_CTRL      8'h03
`define SLC_RST_TEST      8'h00
`define SLC_RST_PINS      8'h00
`define SLC_RST_REQ       1'b0
`define SLC_RST_FMT       1'b1
`define SLC_RST_SCR       1'b1
`define SLC_RST_RDATA     8'h00
`define SLC_RST_PIN_SYNC  2'h3
`define SLC_RD_IDLE       8'h00
// ------------------------------------------------------------
// decoder hit positions and lane grouping
// ------------------------------------------------------------
`define SLC_HIT_SYNC      0
`define SLC_HIT_CTRL      1
`define SLC_HIT_TEST      2
`define SLC_HIT_W         3
`define SLC_LANE_W        8
`define SLC_LANE_GROUP    4
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SLC_BIT_SW_SYNC   0
`define SLC_BIT_SCR       0
`define SLC_BIT_FMT       1
`define SLC_SEL_HI        3
`define SLC_SEL_LO        2
`define SLC_BIT_UPPER     4
`define SLC_TEST_HI       4
`define SLC_BIT_LINK_EN   0
`define SLC_BIT_ENC66     1
`define SLC_BIT_TS_RECV   2
`define SLC_SYNC_MASK     8'h01
`define SLC_CTRL_MASK     8'h1F
`define SLC_TEST_MASK     8'h1F
`define SLC_PINS_MASK     8'h07
// ------------------------------------------------------------
// sync source codes
// ------------------------------------------------------------
`define SLC_SRC_SE        2'h0
`define SLC_SRC_TS        2'h1
`define SLC_SRC_NONE      2'h2
`define SLC_TEST_NORMAL   5'h00
`define SLC_LANES_LOW     8'h0F
`define SLC_LANES_HIGH    8'hF0
`endif

// [logic/slc_pkg.sv]
package slc_pkg;
    typedef logic [11:0] slc_addr_t;
    typedef logic [7:0]  slc_byte_t;
    typedef enum logic [1:0] {SLC_IDLE, SLC_WR, SLC_RD, SLC_WAIT} slc_state_t;
endpackage : slc_pkg

// [logic/slc_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface slc_if;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    modport dev  (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : slc_if
`default_nettype wire

// [logic/slc_device.sv]
// Behaviour
// [R01] software sync bit zero requests sync
// [R02] software keeps sync bit at one
// [R03] software request works with any source
// [R04] low pin holds request until source two
// [R05] upper map zero: lanes 0-3 used
// [R06] upper map one: lanes 4-7 used
// [R07] upper map only for eight-lane modes
// [R08] source select: sync pin, timestamp, none
// [R09] timestamp source needs receiver enable
// [R10] sample format: offset binary or two's complement
// [R11] 8b/10b scrambling follows scrambler enable
// [R12] 64b/66b always scrambles
// [R13] change scrambler only while link disabled
// [R14] test mode zero normal, others patterns
// [R15] request is software OR selected pin
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "slc_consts.svh"
module slc_device
    import slc_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // register access
    slc_if.dev              bus,
    // sync pins, asynchronous, active low
    input  wire logic       single_ended_sync_pin_n,
    input  wire logic       timestamp_pin_n,
    // link mode context
    input  wire logic       link_enable,
    input  wire logic       link_enc_66b,
    // to the link transmitter
    output logic            sync_request,
    output logic [7:0]      link_a_lane_en,
    output logic [7:0]      link_b_lane_en,
    output logic            sample_format,
    output logic            scramble_on,
    output logic [4:0]      link_test_mode
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    slc_byte_t  sw_sync_request_n_reg;
    slc_byte_t  link_control_reg;
    slc_byte_t  link_test_reg;
    slc_byte_t  rdata_reg;
    logic [1:0] se_sync_reg;
    logic [1:0] ts_sync_reg;
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // one decoder serves writes and reads, so no register can answer
    // at one offset and be written at another
    function automatic logic [`SLC_HIT_W-1:0] slc_decode(input slc_addr_t addr);
        logic [`SLC_HIT_W-1:0] hit;
        hit = '0;
        if (addr == `SLC_ADDR_SYNC) begin
            hit[`SLC_HIT_SYNC] = 1'b1;
        end else if (addr == `SLC_ADDR_CTRL) begin
            hit[`SLC_HIT_CTRL] = 1'b1;
        end else if (addr == `SLC_ADDR_TEST) begin
            hit[`SLC_HIT_TEST] = 1'b1;
        end
        return hit;
    endfunction : slc_decode
    wire logic [`SLC_HIT_W-1:0] wr_hit = bus.wr ? slc_decode(bus.addr) : '0;
    wire logic [`SLC_HIT_W-1:0] rd_hit = bus.rd ? slc_decode(bus.addr) : '0;
    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // reserved bits are masked on the way in, so they always read zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sw_sync_request_n_reg <= `SLC_RST_SYNC;
        end else if (wr_hit[`SLC_HIT_SYNC]) begin
            sw_sync_request_n_reg <= bus.wdata & `SLC_SYNC_MASK;
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            link_control_reg <= `SLC_RST_CTRL;
        end else if (wr_hit[`SLC_HIT_CTRL]) begin
            link_control_reg <= bus.wdata & `SLC_CTRL_MASK;
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            link_test_reg <= `SLC_RST_TEST;
        end else if (wr_hit[`SLC_HIT_TEST]) begin
            link_test_reg <= bus.wdata & `SLC_TEST_MASK;
        end
    end
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // a pin may move at any time; only the second flop is read
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            se_sync_reg <= `SLC_RST_PIN_SYNC;
        end else begin
            se_sync_reg <= {se_sync_reg[0], single_ended_sync_pin_n};
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ts_sync_reg <= `SLC_RST_PIN_SYNC;
        end else begin
            ts_sync_reg <= {ts_sync_reg[0], timestamp_pin_n};
        end
    end
    // ------------------------------------------------------------
    // sync request
    // ------------------------------------------------------------
    // code 3 is undefined and reads like code 2, so a stuck pin can
    // always be let go of
    wire logic [1:0] sync_sel = link_control_reg[`SLC_SEL_HI:`SLC_SEL_LO];
    wire logic       se_req   = ~se_sync_reg[1];                                   // R04
    wire logic       ts_req   = ~ts_sync_reg[1];
    wire logic       pin_req  = (sync_sel == `SLC_SRC_SE) ? se_req :               // R08 R04
                                (sync_sel == `SLC_SRC_TS) ? ts_req :               // R08
                                1'b0;
    wire logic       sw_req   = ~sw_sync_request_n_reg[`SLC_BIT_SW_SYNC];          // R01 R03
    wire logic       req_next = sw_req | pin_req;                                  // R15
    // ------------------------------------------------------------
    // lane map
    // ------------------------------------------------------------
    // both links share one map, so one vector serves both of them
    wire logic                   upper = link_control_reg[`SLC_BIT_UPPER];
    wire logic [`SLC_LANE_W-1:0] lanes_next;
    genvar lane;
    generate
        for (lane = 0; lane < `SLC_LANE_W; lane = lane + 1) begin : g_lane
            if (lane < `SLC_LANE_GROUP) begin : g_low
                assign lanes_next[lane] = ~upper;                                  // R05
            end else begin : g_high
                assign lanes_next[lane] = upper;                                   // R06
            end
        end
    endgenerate
    // ------------------------------------------------------------
    // sample coding
    // ------------------------------------------------------------
    // 64b/66b ignores the enable bit entirely
    wire logic       scr_next  = link_enc_66b | link_control_reg[`SLC_BIT_SCR];    // R11 R12
    wire logic       fmt_next  = link_control_reg[`SLC_BIT_FMT];                   // R10
    wire logic [4:0] test_next = link_test_reg[`SLC_TEST_HI:0];                    // R14
    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // an idle bus reads as zero, so read data stand for one cycle only
    wire slc_byte_t  rd_next  =
        rd_hit[`SLC_HIT_SYNC] ? sw_sync_request_n_reg :
        rd_hit[`SLC_HIT_CTRL] ? link_control_reg :
        rd_hit[`SLC_HIT_TEST] ? link_test_reg : `SLC_RD_IDLE;
    // ------------------------------------------------------------
    // outputs, all registered
    // ------------------------------------------------------------
    // the request is a level; the link side finds its own edge
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_request <= `SLC_RST_REQ;
        end else begin
            sync_request <= req_next;                                              // R15
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            link_a_lane_en <= `SLC_LANES_LOW;
        end else begin
            link_a_lane_en <= lanes_next;                                          // R05 R06
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            link_b_lane_en <= `SLC_LANES_LOW;
        end else begin
            link_b_lane_en <= lanes_next;                                          // R05 R06
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sample_format <= `SLC_RST_FMT;
        end else begin
            sample_format <= fmt_next;                                             // R10
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            scramble_on <= `SLC_RST_SCR;
        end else begin
            scramble_on <= scr_next;                                               // R11 R12
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            link_test_mode <= `SLC_TEST_NORMAL;
        end else begin
            link_test_mode <= test_next;                                           // R14
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= `SLC_RST_RDATA;
        end else begin
            rdata_reg <= rd_next;
        end
    end
    assign bus.rdata = rdata_reg;
    // link_enable is context for software ordering only
    wire logic unused_ok = link_enable;
endmodule : slc_device
`default_nettype wire

// [logic/slc_host.sv]
`timescale 1ns/10ps
`default_nettype none
`include "slc_consts.svh"
module slc_host
    import slc_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // device side
    slc_if.host             bus,
    // software port
    input  wire logic [11:0] sw_addr,
    input  wire logic [7:0]  sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic [7:0]       sw_rdata,
    output logic             link_enable,
    output logic             link_enc_66b,
    output logic             timestamp_receiver_enable,
    output logic             order_error
);
    // ------------------------------------------------------------
    // own control register and forwarding
    // ------------------------------------------------------------
    slc_byte_t pins_reg;
    slc_byte_t shadow_ctrl_reg;
    logic      rd_own_reg;
    logic      rd_stat_reg;
    wire logic own_wr  = sw_wr & (sw_addr == `SLC_ADDR_PINS);
    wire logic ctrl_wr = sw_wr & (sw_addr == `SLC_ADDR_CTRL);
    wire logic own_rd  = sw_rd & (sw_addr == `SLC_ADDR_PINS);
    wire logic stat_rd = sw_rd & (sw_addr == `SLC_ADDR_STATUS);
    // scrambler change while the link runs is flagged, not blocked
    wire logic scr_bad = ctrl_wr & pins_reg[`SLC_BIT_LINK_EN] &
                         (sw_wdata[`SLC_BIT_SCR] != shadow_ctrl_reg[`SLC_BIT_SCR]);   // R13
    // timestamp source without receiver enable
    wire logic ts_bad  = ctrl_wr & ~pins_reg[`SLC_BIT_TS_RECV] &
                         (sw_wdata[`SLC_SEL_HI:`SLC_SEL_LO] == `SLC_SRC_TS);         // R09
    // upper map only valid in eight-lane modes
    wire logic up_bad  = ctrl_wr & sw_wdata[`SLC_BIT_UPPER] & pins_reg[`SLC_BIT_ENC66]; // R07
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pins_reg        <= `SLC_RST_PINS;
            shadow_ctrl_reg <= `SLC_RST_CTRL;
            order_error     <= 1'b0;
            rd_own_reg      <= 1'b0;
            rd_stat_reg     <= 1'b0;
        end else begin
            if (own_wr)
                pins_reg <= sw_wdata & `SLC_PINS_MASK;
            if (ctrl_wr)
                shadow_ctrl_reg <= sw_wdata;
            if (scr_bad | ts_bad | up_bad)
                order_error <= 1'b1;
            else if (own_wr)
                order_error <= 1'b0;
            rd_own_reg  <= own_rd;
            rd_stat_reg <= stat_rd;
        end
    end
    // ------------------------------------------------------------
    // forwarding to the device
    // ------------------------------------------------------------
    // strobes pass straight through, so every read answers in the cycle
    // after the software strobe and the port never has to wait
    assign bus.addr  = sw_addr;
    assign bus.wdata = sw_wdata;
    assign bus.wr    = sw_wr & ~own_wr;
    assign bus.rd    = sw_rd & ~own_rd & ~stat_rd;
    assign sw_rdata = rd_own_reg  ? pins_reg :
                      rd_stat_reg ? {7'h00, order_error} : bus.rdata;
    assign link_enable               = pins_reg[`SLC_BIT_LINK_EN];
    assign link_enc_66b              = pins_reg[`SLC_BIT_ENC66];
    assign timestamp_receiver_enable = pins_reg[`SLC_BIT_TS_RECV];
endmodule : slc_host
`default_nettype wire

// [sim/slc_checker.sv]
`timescale 1ns/10ps
`default_nettype none
// ----
// link control checks
// ----
module slc_checker (
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       sync_request,
    input wire logic [7:0] link_a_lane_en,
    input wire logic [7:0] link_b_lane_en,
    input wire logic       sample_format,
    input wire logic       scramble_on,
    input wire logic       link_enc_66b,
    input wire logic [4:0] link_test_mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire logic wc = wr && addr == 12'h204;
    property p_lanes;
        link_a_lane_en == link_b_lane_en && (link_a_lane_en == 8'h0F || link_a_lane_en == 8'hF0);
    endproperty
    a_lanes: assert property (p_lanes) else $error("lane enables inconsistent");
    property p_upper;
        wc |-> ##2 link_a_lane_en == ($past(wdata[4], 2) ? 8'hF0 : 8'h0F);
    endproperty
    a_upper: assert property (p_upper) else $error("lane map not applied");
    property p_fmt;
        wc |-> ##2 sample_format == $past(wdata[1], 2);
    endproperty
    a_fmt: assert property (p_fmt) else $error("sample format not applied");
    property p_scr66;
        $past(link_enc_66b) |-> scramble_on;
    endproperty
    a_scr66: assert property (p_scr66) else $error("wide coding not scrambled");
    property p_scroff;
        wc && !wdata[0] ##1 !link_enc_66b |=> !scramble_on;
    endproperty
    a_scroff: assert property (p_scroff) else $error("scrambler not turned off");
    property p_sync;
        wr && addr == 12'h203 && !wdata[0] |-> ##2 sync_request;
    endproperty
    a_sync: assert property (p_sync) else $error("software request lost");
    property p_test;
        wr && addr == 12'h205 |-> ##2 link_test_mode == $past(wdata[4:0], 2);
    endproperty
    a_test: assert property (p_test) else $error("test mode not applied");
    property p_rsv;
        rd && addr == 12'h203 |=> rdata[7:1] == 7'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
endmodule : slc_checker
`default_nettype wire

// [sim/test_serial_link_sync_lane_control.sv]
`timescale 1ns/10ps
`default_nettype none
module test_serial_link_sync_lane_control;
    import slc_pkg::*;
    logic mclk = 0, sys_rst = 1, sw_wr = 0, sw_rd = 0, se_n = 1, ts_n = 1;
    logic [11:0] sw_addr = 12'h000;
    logic [7:0] sw_wdata = 8'h00;
    wire logic link_enable, link_enc_66b, order_error, sync_request, sample_format, scramble_on;
    wire logic timestamp_receiver_enable;
    wire logic [7:0] sw_rdata, link_a_lane_en, link_b_lane_en;
    wire logic [4:0] link_test_mode;
    int n_errors = 0, checks_done = 0;
    slc_if bus_if ();
    slc_host u_slc_host (.mclk, .sys_rst, .bus(bus_if.host), .sw_addr, .sw_wdata, .sw_wr,
        .sw_rd, .sw_rdata, .link_enable, .link_enc_66b, .timestamp_receiver_enable,
        .order_error);
    slc_device u_slc_device (.mclk, .sys_rst, .bus(bus_if.dev), .single_ended_sync_pin_n(se_n),
        .timestamp_pin_n(ts_n), .link_enable, .link_enc_66b, .sync_request, .link_a_lane_en,
        .link_b_lane_en, .sample_format, .scramble_on, .link_test_mode);
    slc_checker u_slc_checker (.mclk, .sys_rst, .addr(bus_if.addr), .wdata(bus_if.wdata),
        .wr(bus_if.wr),
        .rd(bus_if.rd), .rdata(bus_if.rdata), .sync_request, .link_a_lane_en, .link_b_lane_en,
        .sample_format, .scramble_on, .link_enc_66b, .link_test_mode);
    always #5 mclk = ~mclk;
    // ----
    // access tasks
    // ----
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // outputs settle two edges after the software strobe
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        sw_addr <= a; sw_wdata <= d; sw_wr <= 1'b1;
        @(posedge mclk);
        sw_wr <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge mclk);
        sw_addr <= a; sw_rd <= 1'b1;
        @(posedge mclk);
        sw_rd <= 1'b0;
        #1 chk(sw_rdata, e);
    endtask : rd
    // pins pass a two-flop synchroniser first
    task automatic pin(input logic se, input logic ts);
        @(posedge mclk);
        se_n <= se; ts_n <= ts;
        repeat (5) @(posedge mclk);
        #1;
    endtask : pin
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    initial begin
        #200us;
        n_errors++;
        stop_test;
    end
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk({7'h00, sync_request}, 8'h00);
        chk(link_a_lane_en, 8'h0F);
        chk({7'h00, sample_format}, 8'h01);
        chk({7'h00, scramble_on}, 8'h01);
        rd(12'h203, 8'h01);
        rd(12'h204, 8'h03);
        rd(12'h205, 8'h00);
        rd(12'h2FF, 8'h00);
        wr(12'h204, 8'hFF);
        rd(12'h204, 8'h1F);
        chk(link_b_lane_en, 8'hF0);
        wr(12'h204, 8'h00);
        chk(link_b_lane_en, 8'h0F);
        chk({7'h00, sample_format}, 8'h00);
        chk({7'h00, scramble_on}, 8'h00);
        pin(1'b0, 1'b1);
        chk({7'h00, sync_request}, 8'h01);
        pin(1'b1, 1'b0);
        chk({7'h00, sync_request}, 8'h00);
        wr(12'h210, 8'h04);
        rd(12'h210, 8'h04);
        chk({7'h00, timestamp_receiver_enable}, 8'h01);
        wr(12'h204, 8'h04);
        chk({7'h00, sync_request}, 8'h01);
        pin(1'b0, 1'b1);
        chk({7'h00, sync_request}, 8'h00);
        wr(12'h204, 8'h00);
        chk({7'h00, sync_request}, 8'h01);
        wr(12'h204, 8'h08);
        chk({7'h00, sync_request}, 8'h00);
        wr(12'h203, 8'h00);
        chk({7'h00, sync_request}, 8'h01);
        rd(12'h203, 8'h00);
        wr(12'h203, 8'h01);
        chk({7'h00, sync_request}, 8'h00);
        wr(12'h210, 8'h02);
        chk({7'h00, scramble_on}, 8'h01);
        wr(12'h210, 8'h01);
        chk({7'h00, link_enable}, 8'h01);
        chk({7'h00, order_error}, 8'h00);
        wr(12'h204, 8'h09);
        rd(12'h211, 8'h01);
        chk({7'h00, order_error}, 8'h01);
        for (int i = 0; i < 17; i++) begin
            wr(12'h205, i[7:0]);
            chk({3'h0, link_test_mode}, i[7:0]);
        end
        wr(12'h205, 8'hFF);
        rd(12'h205, 8'h1F);
        wr(12'h210, 8'h02);
        wr(12'h204, 8'h10);
        chk({7'h00, order_error}, 8'h01);
        chk(link_a_lane_en, 8'hF0);
        wr(12'h210, 8'h00);
        chk({7'h00, order_error}, 8'h00);
        wr(12'h204, 8'h04);
        rd(12'h211, 8'h01);
        stop_test;
    end
endmodule : test_serial_link_sync_lane_control
`default_nettype wire
